// >>> twd_pkg.sv
package twd_pkg;
  // Register file addresses
  localparam logic [7:0] ADDR_CNT_HI  = 8'hf8;
  localparam logic [7:0] ADDR_CNT_LO  = 8'hf9;
  localparam logic [7:0] ADDR_PRESC   = 8'hfa;
  localparam logic [7:0] ADDR_CTRL    = 8'hfb;
  localparam logic [7:0] ADDR_WAIT    = 8'hfc;
  localparam logic [7:0] ADDR_IRQ_SEL = 8'hfd;
  // Reset values
  localparam logic [7:0] RST_CNT      = 8'hff;
  localparam logic [7:0] RST_PRESC    = 8'hff;
  localparam logic [7:0] RST_CTRL     = 8'h12;
  localparam logic [7:0] RST_WAIT     = 8'h7f;
  localparam logic [7:0] RST_IRQ_SEL  = 8'h06;
  // Control field positions
  localparam int CTRL_RUN    = 7;
  localparam int CTRL_SINGLE = 6;
  localparam int CTRL_MD_HI  = 5;
  localparam int CTRL_MD_LO  = 4;
  localparam int CTRL_IN_ON  = 3;
  localparam int CTRL_OSTYLE = 2;
  localparam int CTRL_PWM    = 1;
  localparam int CTRL_OUT_ON = 0;
  localparam int WAIT_WDG_N  = 6;
  localparam int SEL_TOP_SRC = 2;
  localparam int SEL_A0_SRC  = 1;
  localparam int CLKFLAG_WDG = 6;
  // Internal clock divided by four
  localparam logic [1:0] QDIV_LAST = 2'h3;
  // Watchdog service keys
  localparam logic [7:0] KEY_A = 8'haa;
  localparam logic [7:0] KEY_B = 8'h55;
  typedef enum logic [1:0] {
    MODE_EVENT = 2'b00,
    MODE_GATED = 2'b01,
    MODE_TRIG  = 2'b10,
    MODE_RETRG = 2'b11
  } twd_mode_t;
endpackage : twd_pkg

// >>> twd_prescaler.sv
`timescale 1ns/1ps
module twd_prescaler #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic         clear_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);
  import twd_pkg::*;
  if (W < 1) begin : g_bad_width
    $error("prescaler width must be positive");
  end
  logic [W-1:0] cnt_ff;
  wire          wrap = (cnt_ff >= div_i);
  // Divide by value plus one; value change acts at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (clear_i) begin
      cnt_ff <= '0;
    end else if (tick_i) begin
      cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
    end
  end
  assign tick_o = tick_i && wrap;
endmodule : twd_prescaler

// >>> twd_core.sv
`timescale 1ns/1ps
// Overview of operation
// - Every end of count outside watchdog mode raises an interrupt request when the source is enabled.
// - Top-level select bit 2: 0 picks end of count when bit 1 is one, 1 picks NMI pin.
// - Channel A0 select bit 1: 0 picks end of count, 1 picks external pin.
// - Watchdog mode: expiry resets, selected channels become software trap only.
// - With both selects zero only channel A0 is raised.
// - Writing a pending bit to one makes a software trap.
// - Watchdog reset sets bit 6 of the clock flag register.
// - Counter split in high byte 15:8 and low byte 7:0, accessible running.
// - Counter bytes and prescaler reset to all ones.
// - Prescaler divides by value plus one.
// - Control register resets to 12h.
// - Bit 7 run, bit 6 single mode.
// - Bits 5:4 select event, gated, triggerable, retriggerable input.
// - Bit 3 enables the input section.
// - Bit 2 chooses toggle or level transfer at end of count.
// - Bit 1 level for PWM output, set by reset.
// - Bit 0 enables the timer output.
// - Wait bit 6 active-low watchdog enable, clear-only, set by reset.
// - Software enable ignored when hardware watchdog strap selected.
// - End of count is the down-counter reaching zero.
// - End of count in watchdog mode gives a system reset.
module twd_core (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ext_rst_i,
  input  wire logic       hw_sw_watchdog_strap_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       ext_irq_channel_a0_i,
  input  wire logic       nmi_i,
  input  wire logic       timer_in_i,
  input  wire logic       a0_ack_i,
  input  wire logic       tl_ack_i,
  input  wire logic       a0_pend_wr_i,
  input  wire logic       a0_pend_val_i,
  input  wire logic       tl_pend_wr_i,
  input  wire logic       tl_pend_val_i,
  input  wire logic       clkflag_clr_i,
  output logic [7:0]      rdata_o,
  output logic            a0_pend_o,
  output logic            tl_pend_o,
  output logic            sys_reset_o,
  output logic            watchdog_reset_flag_o,
  output logic            timer_output_pin_o
);
  import twd_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  hi_ff, lo_ff, presc_ff, ctrl_ff, irq_sel_ff;
  logic        wdg_n_ff, hw_wdg_ff, strap_seen_ff;
  logic [15:0] cnt_ff;
  logic [1:0]  qdiv_ff;
  logic        in_d_ff, armed_ff, key_ff, reload_pend_ff;
  logic [7:0]  rdata_ff;
  logic        a0_ff, tl_ff, sysrst_ff, wflag_ff, out_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_hi    = wr_i && (addr_i == ADDR_CNT_HI);
  wire wr_lo    = wr_i && (addr_i == ADDR_CNT_LO);
  wire wr_presc = wr_i && (addr_i == ADDR_PRESC);
  wire wr_ctrl  = wr_i && (addr_i == ADDR_CTRL);
  wire wr_wait  = wr_i && (addr_i == ADDR_WAIT);
  wire wr_irq_sel = wr_i && (addr_i == ADDR_IRQ_SEL);

  // Watchdog mode: software clear unless strap forces hardware mode
  wire wdg_mode  = hw_wdg_ff || !wdg_n_ff;
  wire top_src_sel = irq_sel_ff[SEL_TOP_SRC];
  wire a0_src_sel  = irq_sel_ff[SEL_A0_SRC];
  twd_mode_t mode;
  assign mode    = twd_mode_t'(ctrl_ff[CTRL_MD_HI:CTRL_MD_LO]);
  wire run       = ctrl_ff[CTRL_RUN] || wdg_mode;
  wire in_on     = ctrl_ff[CTRL_IN_ON] && !wdg_mode;
  wire in_fall   = in_d_ff && !timer_in_i;
  wire qtick     = (qdiv_ff == QDIV_LAST);

  // Clock source and gating per input mode
  wire gate_ok   = !in_on || (mode == MODE_EVENT) || (mode == MODE_RETRG)
                   || ((mode == MODE_GATED) && timer_in_i)
                   || ((mode == MODE_TRIG) && armed_ff);
  wire src_tick  = (in_on && mode == MODE_EVENT) ? in_fall : qtick;
  wire pre_tick;
  wire retrig    = in_on && (mode == MODE_RETRG) && in_fall && run;

  twd_prescaler #(.W(8)) u_presc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (src_tick && run && gate_ok),
    .clear_i (1'b0),
    .div_i   (presc_ff),
    .tick_o  (pre_tick)
  );

  wire const_sel = !hw_wdg_ff;
  wire [15:0] reload_val = const_sel ? {hi_ff, lo_ff} : {RST_CNT, RST_CNT};
  wire eoc       = pre_tick && (cnt_ff == '0);
  wire service   = wdg_mode && wr_lo && key_ff && (wdata_i == KEY_B);
  wire wdg_fire  = eoc && wdg_mode;
  wire timer_ev  = eoc && !wdg_mode;

  // Routing: watchdog mode leaves only software traps on EOC channels
  wire a0_set    = a0_src_sel ? ext_irq_channel_a0_i : timer_ev;
  wire tl_src    = top_src_sel ? nmi_i : (timer_ev && a0_src_sel);
  wire single_stop = timer_ev && ctrl_ff[CTRL_SINGLE];

  wire [7:0] rd_mux =
    (addr_i == ADDR_CNT_HI) ? cnt_ff[15:8] :
    (addr_i == ADDR_CNT_LO) ? cnt_ff[7:0] :
    (addr_i == ADDR_PRESC)  ? presc_ff :
    (addr_i == ADDR_CTRL)   ? ctrl_ff :
    (addr_i == ADDR_WAIT)   ? {1'b0, wdg_n_ff, 6'h3f} :
    (addr_i == ADDR_IRQ_SEL) ? irq_sel_ff : 8'h00;

  wire [7:0] nxt_ctrl = wr_ctrl ? wdata_i
                      : (single_stop ? (ctrl_ff & ~(8'h01 << CTRL_RUN)) : ctrl_ff);
  wire nxt_out = !ctrl_ff[CTRL_OUT_ON] ? 1'b1 :
                 !eoc ? out_ff :
                 ctrl_ff[CTRL_OSTYLE] ? ctrl_ff[CTRL_PWM] : !out_ff;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_ff    <= RST_CNT;
      lo_ff    <= RST_CNT;
      presc_ff <= RST_PRESC;
      ctrl_ff  <= RST_CTRL;
      irq_sel_ff <= RST_IRQ_SEL;
      wdg_n_ff <= RST_WAIT[WAIT_WDG_N];
    end else begin
      if (wr_hi && !wdg_mode) hi_ff <= wdata_i;
      if (wr_lo && !wdg_mode) lo_ff <= wdata_i;
      if (wr_presc) presc_ff <= wdata_i;
      ctrl_ff <= nxt_ctrl;
      if (wr_irq_sel) irq_sel_ff <= wdata_i;
      if (wr_wait && !wdata_i[WAIT_WDG_N]) wdg_n_ff <= 1'b0;
    end
  end

  // Strap captured after reset release
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hw_wdg_ff     <= 1'b0;
      strap_seen_ff <= 1'b0;
    end else if (!strap_seen_ff) begin
      hw_wdg_ff     <= !hw_sw_watchdog_strap_i;
      strap_seen_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff         <= {RST_CNT, RST_CNT};
      qdiv_ff        <= '0;
      in_d_ff        <= 1'b1;
      armed_ff       <= 1'b0;
      key_ff         <= 1'b0;
      reload_pend_ff <= 1'b0;
    end else begin
      qdiv_ff <= qdiv_ff + 2'h1;
      in_d_ff <= timer_in_i;
      if (!ctrl_ff[CTRL_RUN]) armed_ff <= 1'b0;
      else if (in_fall) armed_ff <= 1'b1;
      if (wr_lo) key_ff <= (wdata_i == KEY_A);
      if ((wr_hi || wr_lo) && !wdg_mode && !run) reload_pend_ff <= 1'b1;
      if (service || retrig || eoc || (reload_pend_ff && run)) begin
        cnt_ff         <= reload_val;
        reload_pend_ff <= 1'b0;
      end else if (pre_tick) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Interrupts, reset, output
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      a0_ff     <= 1'b0;
      tl_ff     <= 1'b0;
      sysrst_ff <= 1'b0;
      out_ff    <= 1'b1;
      rdata_ff  <= 8'h00;
    end else begin
      // Set wins over clear
      if (a0_set) a0_ff <= 1'b1;
      else if (a0_pend_wr_i) a0_ff <= a0_pend_val_i;
      else if (a0_ack_i) a0_ff <= 1'b0;
      if (tl_src) tl_ff <= 1'b1;
      else if (tl_pend_wr_i) tl_ff <= tl_pend_val_i;
      else if (tl_ack_i) tl_ff <= 1'b0;
      sysrst_ff <= wdg_fire || ext_rst_i;
      out_ff    <= nxt_out;
      if (rd_i) rdata_ff <= rd_mux;
    end
  end

  // Flag survives the system reset it causes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wflag_ff <= 1'b0;
    end else if (wdg_fire) begin
      wflag_ff <= 1'b1;
    end else if (clkflag_clr_i) begin
      wflag_ff <= 1'b0;
    end
  end

  assign rdata_o               = rdata_ff;
  assign a0_pend_o             = a0_ff;
  assign tl_pend_o             = tl_ff;
  assign sys_reset_o           = sysrst_ff;
  assign watchdog_reset_flag_o = wflag_ff;
  assign timer_output_pin_o    = out_ff;
endmodule : twd_core

// >>> twd_core_checker.sv
`timescale 1ns/1ps
module twd_core_checker (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ext_rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       ext_irq_channel_a0_i,
  input wire logic       nmi_i,
  input wire logic       a0_ack_i,
  input wire logic       a0_pend_wr_i,
  input wire logic       a0_pend_val_i,
  input wire logic       tl_pend_wr_i,
  input wire logic       clkflag_clr_i,
  input wire logic [7:0] rdata_o,
  input wire logic       a0_pend_o,
  input wire logic       tl_pend_o,
  input wire logic       sys_reset_o,
  input wire logic       watchdog_reset_flag_o
);
  import twd_pkg::*;
  // ----------
  // Select shadow
  // ----------
  logic tl_sel_ff;
  logic a0_sel_ff;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tl_sel_ff <= 1'b1;
      a0_sel_ff <= 1'b1;
    end else if (wr_i && addr_i == ADDR_IRQ_SEL) begin
      tl_sel_ff <= wdata_i[SEL_TOP_SRC];
      a0_sel_ff <= wdata_i[SEL_A0_SRC];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ext_rst_follow: assert property (ext_rst_i |=> sys_reset_o)
    else $error("external reset not forwarded");
  a_flag_cause: assert property (sys_reset_o && !$past(ext_rst_i) |-> ##[0:1] watchdog_reset_flag_o)
    else $error("watchdog reset flag not set");
  a_flag_sticky: assert property (watchdog_reset_flag_o && !clkflag_clr_i |=> watchdog_reset_flag_o)
    else $error("watchdog reset flag lost");
  a_nmi_top: assert property (nmi_i && tl_sel_ff |=> tl_pend_o)
    else $error("nmi did not set top-level pending");
  a_a0_ext_pin: assert property (ext_irq_channel_a0_i && a0_sel_ff |=> a0_pend_o)
    else $error("pin did not set channel a0 pending");
  a_a0_sw_trap: assert property (a0_pend_wr_i && a0_pend_val_i |=> a0_pend_o)
    else $error("software trap not pended");
  a_a0_pend_hold: assert property (a0_pend_o && !a0_ack_i && !(a0_pend_wr_i && !a0_pend_val_i)
    |=> a0_pend_o)
    else $error("channel a0 pending dropped");
  a_top_masked: assert property (!tl_sel_ff && !a0_sel_ff && !tl_pend_o && !tl_pend_wr_i
    |=> !tl_pend_o)
    else $error("top-level raised with both selects zero");
  a_rdata_stands: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data changed without read");
  c_wdg_reset: cover property (sys_reset_o && !ext_rst_i);
  c_a0_timer: cover property (a0_pend_o && !a0_sel_ff);
  c_top_nmi: cover property (tl_pend_o && tl_sel_ff);
endmodule : twd_core_checker

bind twd_core twd_core_checker u_chk (.clk_i, .rst_i, .ext_rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .ext_irq_channel_a0_i, .nmi_i, .a0_ack_i, .a0_pend_wr_i, .a0_pend_val_i,
  .tl_pend_wr_i, .clkflag_clr_i, .rdata_o, .a0_pend_o, .tl_pend_o, .sys_reset_o,
  .watchdog_reset_flag_o);

// >>> twd_core_tb_top.sv
`timescale 1ns/1ps
module twd_core_tb_top;
  import twd_pkg::*;
  logic       clk_i = 1'b0, rst_i = 1'b1, ext_rst_i = 1'b0, hw_sw_watchdog_strap_i = 1'b1;
  logic       wr_i = 1'b0, rd_i = 1'b0, ext_irq_channel_a0_i = 1'b0, nmi_i = 1'b0;
  logic       timer_in_i = 1'b1, a0_ack_i = 1'b0, tl_ack_i = 1'b0, a0_pend_wr_i = 1'b0;
  logic       a0_pend_val_i = 1'b0, tl_pend_wr_i = 1'b0, tl_pend_val_i = 1'b0;
  logic       clkflag_clr_i = 1'b0, a0_pend_o, tl_pend_o, sys_reset_o, pin;
  logic       watchdog_reset_flag_o, timer_output_pin_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  int         mismatches = 0, n_checks = 0, i;

  always #12.5 clk_i = ~clk_i;

  twd_core uut (.clk_i, .rst_i, .ext_rst_i, .hw_sw_watchdog_strap_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .ext_irq_channel_a0_i, .nmi_i, .timer_in_i, .a0_ack_i, .tl_ack_i, .a0_pend_wr_i,
    .a0_pend_val_i, .tl_pend_wr_i, .tl_pend_val_i, .clkflag_clr_i, .rdata_o, .a0_pend_o,
    .tl_pend_o, .sys_reset_o, .watchdog_reset_flag_o, .timer_output_pin_o);

  // ----------
  // Access tasks
  // ----------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    chk(rdata_o, exp);
  endtask : rd

  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask : pulse

  task automatic wait_hi(ref logic s);
    int k;
    for (k = 0; k < 300 && s !== 1'b1; k++) @(negedge clk_i);
    chk({7'h0, s}, 8'h01);
  endtask : wait_hi

  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    #(5000 * 25);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    rd(ADDR_CNT_HI, RST_CNT);
    rd(ADDR_CNT_LO, RST_CNT);
    rd(ADDR_PRESC, RST_PRESC);
    rd(ADDR_CTRL, RST_CTRL);
    rd(ADDR_WAIT, RST_WAIT);
    rd(ADDR_IRQ_SEL, RST_IRQ_SEL);
    rd(8'hf0, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, {2'b01, i[1:0], 4'h6});
      rd(ADDR_CTRL, {2'b01, i[1:0], 4'h6});
    end
    wr(ADDR_PRESC, 8'h00);
    rd(ADDR_PRESC, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h02);
    wr(ADDR_IRQ_SEL, 8'h00);
    wr(ADDR_CTRL, 8'h81);
    wait_hi(a0_pend_o);
    chk({7'h0, tl_pend_o}, 8'h00);
    @(negedge clk_i);
    pin = timer_output_pin_o;
    pulse(a0_ack_i);
    chk({7'h0, a0_pend_o}, 8'h00);
    wait_hi(a0_pend_o);
    @(negedge clk_i);
    chk({7'h0, timer_output_pin_o}, {7'h0, ~pin});
    wr(ADDR_CTRL, 8'h80);
    @(negedge clk_i);
    chk({7'h0, timer_output_pin_o}, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    pulse(a0_ack_i);
    @(negedge clk_i);
    wr(ADDR_IRQ_SEL, RST_IRQ_SEL);
    pulse(a0_ack_i);
    pulse(nmi_i);
    chk({7'h0, tl_pend_o}, 8'h01);
    pulse(ext_irq_channel_a0_i);
    chk({7'h0, a0_pend_o}, 8'h01);
    pulse(tl_ack_i);
    pulse(a0_ack_i);
    a0_pend_val_i = 1'b1;
    pulse(a0_pend_wr_i);
    chk({7'h0, a0_pend_o}, 8'h01);
    a0_pend_val_i = 1'b0;
    pulse(a0_pend_wr_i);
    chk({7'h0, a0_pend_o}, 8'h00);
    // Single mode with level transfer: pin takes level 0, run bit drops
    wr(ADDR_CTRL, 8'hc5);
    repeat (20) @(negedge clk_i);
    chk({7'h0, timer_output_pin_o}, 8'h00);
    rd(ADDR_CTRL, 8'h45);
    pulse(ext_rst_i);
    chk({7'h0, sys_reset_o}, 8'h01);
    wr(ADDR_IRQ_SEL, 8'h00);
    wr(ADDR_WAIT, 8'h3f);
    wr(ADDR_WAIT, RST_WAIT);
    rd(ADDR_WAIT, 8'h3f);
    wait_hi(sys_reset_o);
    @(negedge clk_i);
    chk({7'h0, watchdog_reset_flag_o}, 8'h01);
    chk({7'h0, a0_pend_o}, 8'h00);
    pulse(clkflag_clr_i);
    chk({7'h0, watchdog_reset_flag_o}, 8'h00);
    report_and_stop();
  end
endmodule : twd_core_tb_top
